// ### urx_receiver.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module urx_receiver (
  input wire logic mclk_i,            // system clock
  input wire logic rst_i,             // sync reset, high
  input wire logic serial_in_pin_i,   // serial line, idle high
  input wire logic [7:0] s_axi_awaddr_i,  // write address
  input wire logic s_axi_awvalid_i,   // write address valid
  output logic s_axi_awready_o,       // write address ready
  input wire logic [31:0] s_axi_wdata_i,  // write data
  input wire logic [3:0] s_axi_wstrb_i,   // byte strobes
  input wire logic s_axi_wvalid_i,    // write data valid
  output logic s_axi_wready_o,        // write data ready
  output logic [1:0] s_axi_bresp_o,   // write response
  output logic s_axi_bvalid_o,        // write response valid
  input wire logic s_axi_bready_i,    // write response ready
  input wire logic [7:0] s_axi_araddr_i,  // read address
  input wire logic s_axi_arvalid_i,   // read address valid
  output logic s_axi_arready_o,       // read address ready
  output logic [31:0] s_axi_rdata_o,  // read data
  output logic [1:0] s_axi_rresp_o,   // read response
  output logic s_axi_rvalid_o,        // read valid
  input wire logic s_axi_rready_i,    // read ready
  output logic rx_irq_o               // receive irq pulse
);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP,
    RX_STOP2
  } urx_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [15:0] bcnt;
    logic tick;
    urx_st_t st;
    logic [3:0] ph;
    logic [3:0] bitn;
    logic sa;
    logic sb;
    logic [8:0] rx_shift_reg;
    logic par;
    logic nf_acc;
    logic fe_acc;
    logic [1:0][10:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic rx_avail_flag;
    logic overrun_flag;
    logic noise_flag;
    logic rx_idle_flag;
    logic armed;
    logic port_on_bit;
    logic rx_enable_bit;
    logic word_length_sel;
    logic parity_en;
    logic parity_type_sel;
    logic stop2;
    logic rx_irq_en;
    logic [15:0] baud_divisor;
    logic irq;
    logic awrdy;
    logic awgot;
    logic [7:0] awa;
    logic wrdy;
    logic wgot;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } urx_state_t;

  urx_state_t q;
  urx_state_t n;
  logic push;
  logic ovf;
  logic pop;
  logic done;
  logic fe_now;
  logic maj;
  logic noisy;
  logic [3:0] nbits;
  logic [8:0] word;
  logic pe_now;
  logic [10:0] head;
  logic [31:0] stat;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    push = 1'b0;
    ovf = 1'b0;
    pop = 1'b0;
    done = 1'b0;
    fe_now = 1'b0;
    word = q.rx_shift_reg;
    pe_now = 1'b0;
    head = q.fifo[q.rp];
    stat = 32'h0000_0000;
    maj = (q.sa & q.sb) | (q.sa & q.s2) | (q.sb & q.s2);
    noisy = !((q.sa == q.sb) && (q.sb == q.s2));
    nbits = q.word_length_sel ? urx_pkg::NBITS_9 : urx_pkg::NBITS_8;
    n.s1 = serial_in_pin_i;
    n.s2 = q.s1;
    n.irq = 1'b0;
    n.tick = 1'b0;
    // 16x tick every divisor+1 clocks
    if (q.bcnt == 16'h0000) begin
      n.bcnt = q.baud_divisor;
      n.tick = 1'b1;
    end else begin
      n.bcnt = q.bcnt - 16'h0001;
    end

    // status image; frame and parity bits belong to the head word
    stat[urx_pkg::ST_AVAIL] = q.rx_avail_flag;
    stat[urx_pkg::ST_OVR] = q.overrun_flag;
    stat[urx_pkg::ST_NOISE] = q.noise_flag;
    stat[urx_pkg::ST_FRAME] = (q.cnt != 2'h0) && head[urx_pkg::ENT_FE];
    stat[urx_pkg::ST_PAR] = (q.cnt != 2'h0) && head[urx_pkg::ENT_PE];
    stat[urx_pkg::ST_IDLE] = q.rx_idle_flag;

    //////////////////////////////////////////////////////////////////
    // register write channel
    if (q.awrdy && s_axi_awvalid_i) begin
      n.awgot = 1'b1;
      n.awa = s_axi_awaddr_i;
    end
    if (q.wrdy && s_axi_wvalid_i) begin
      n.wgot = 1'b1;
      n.wd = s_axi_wdata_i;
      n.ws = s_axi_wstrb_i;
    end
    if (q.awgot && q.wgot && !q.bvalid) begin
      n.awgot = 1'b0;
      n.wgot = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = urx_pkg::RESP_OKAY;
      if (q.awa == urx_pkg::OFF_CTRL) begin
        if (q.ws[0]) begin
          n.port_on_bit = q.wd[urx_pkg::CT_ON];
          n.rx_enable_bit = q.wd[urx_pkg::CT_RXEN];
          n.word_length_sel = q.wd[urx_pkg::CT_WL];
          n.parity_en = q.wd[urx_pkg::CT_PEN];
          n.parity_type_sel = q.wd[urx_pkg::CT_PTYPE];
          n.stop2 = q.wd[urx_pkg::CT_STOP2];
          n.rx_irq_en = q.wd[urx_pkg::CT_IRQEN];
        end
      end else if (q.awa == urx_pkg::OFF_BAUD) begin
        if (q.ws[0]) begin
          n.baud_divisor[7:0] = q.wd[7:0];
        end
        if (q.ws[1]) begin
          n.baud_divisor[15:8] = q.wd[15:8];
        end
      end else if (q.awa != urx_pkg::OFF_STAT && q.awa != urx_pkg::OFF_DATA) begin
        n.bresp = urx_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    n.awrdy = !n.awgot && !n.bvalid;
    n.wrdy = !n.wgot && !n.bvalid;

    //////////////////////////////////////////////////////////////////
    // register read channel
    if (q.arrdy && s_axi_arvalid_i) begin
      n.rvalid = 1'b1;
      n.rresp = urx_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        urx_pkg::OFF_STAT: begin
          n.rdata = stat;
          n.armed = 1'b1;
        end
        urx_pkg::OFF_CTRL: begin
          n.rdata[urx_pkg::CT_ON] = q.port_on_bit;
          n.rdata[urx_pkg::CT_RXEN] = q.rx_enable_bit;
          n.rdata[urx_pkg::CT_WL] = q.word_length_sel;
          n.rdata[urx_pkg::CT_PEN] = q.parity_en;
          n.rdata[urx_pkg::CT_PTYPE] = q.parity_type_sel;
          n.rdata[urx_pkg::CT_STOP2] = q.stop2;
          n.rdata[urx_pkg::CT_IRQEN] = q.rx_irq_en;
          n.rdata[urx_pkg::CT_NINTH] = (q.cnt != 2'h0) && head[8];
        end
        urx_pkg::OFF_BAUD: begin
          n.rdata[15:0] = q.baud_divisor;
        end
        urx_pkg::OFF_DATA: begin
          // only the buffer is visible here
          n.rdata[7:0] = (q.cnt != 2'h0) ? head[7:0] : 8'h00;
          n.armed = 1'b0;
          if (q.armed && q.cnt != 2'h0) begin
            pop = 1'b1;
          end
          if (q.armed) begin
            n.overrun_flag = 1'b0;
            n.noise_flag = 1'b0;
            if (q.cnt <= 2'h1) begin
              n.rx_avail_flag = 1'b0;
            end
          end
        end
        default: begin
          n.rresp = urx_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    n.arrdy = !n.rvalid;

    //////////////////////////////////////////////////////////////////
    // serial recovery
    if (q.tick) begin
      n.prev = q.s2;
      if (q.st != RX_IDLE) begin
        n.ph = q.ph + 4'h1;
      end
      if (q.ph == urx_pkg::PH_SAMP_A) begin
        n.sa = q.s2;
      end
      if (q.ph == urx_pkg::PH_SAMP_B) begin
        n.sb = q.s2;
      end
      unique case (q.st)
        RX_IDLE: begin
          // a low line after break shows no edge
          if (q.rx_enable_bit && q.prev && !q.s2) begin
            n.st = RX_START;
            n.ph = 4'h1;
            n.rx_idle_flag = 1'b0;
            n.nf_acc = 1'b0;
            n.fe_acc = 1'b0;
            n.par = 1'b0;
            n.bitn = 4'h0;
            n.rx_shift_reg = 9'h000;
          end
        end
        RX_START: begin
          if (q.ph == urx_pkg::PH_SAMP_C) begin
            n.nf_acc = noisy;
            if (maj) begin
              n.st = RX_IDLE;
              n.rx_idle_flag = 1'b1;
            end
          end else if (q.ph == urx_pkg::PH_LAST) begin
            n.st = RX_DATA;
          end
        end
        RX_DATA: begin
          if (q.ph == urx_pkg::PH_SAMP_C) begin
            n.rx_shift_reg[q.bitn] = maj;
            n.par = q.par ^ maj;
            n.nf_acc = q.nf_acc | noisy;
            n.bitn = q.bitn + 4'h1;
          end else if (q.ph == urx_pkg::PH_LAST && q.bitn == nbits) begin
            n.st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (q.ph == urx_pkg::PH_SAMP_C) begin
            n.nf_acc = q.nf_acc | noisy;
            if (q.stop2) begin
              n.fe_acc = !maj;
            end else begin
              done = 1'b1;
              fe_now = !maj;
            end
          end else if (q.ph == urx_pkg::PH_LAST && q.stop2) begin
            n.st = RX_STOP2;
          end
        end
        RX_STOP2: begin
          if (q.ph == urx_pkg::PH_SAMP_C) begin
            n.nf_acc = q.nf_acc | noisy;
            done = 1'b1;
            fe_now = q.fe_acc | !maj;
          end
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////
    // word completion, buffer and flags
    if (q.parity_en) begin
      word[nbits - 4'h1] = 1'b0;
    end
    if (!q.word_length_sel) begin
      word[8] = 1'b0;
    end
    pe_now = q.parity_en && (q.par ^ q.parity_type_sel);
    if (done) begin
      n.st = RX_IDLE;
      n.rx_idle_flag = 1'b1;
      if (q.cnt == 2'h2 && !pop) begin
        ovf = 1'b1;
      end else begin
        push = 1'b1;
      end
    end
    if (!n.port_on_bit) begin
      push = 1'b0;
      ovf = 1'b0;
    end
    if (push) begin
      n.fifo[q.wp] = {pe_now, fe_now, word};
      n.wp = !q.wp;
      n.rx_avail_flag = 1'b1;
      if (q.nf_acc || noisy) begin
        n.noise_flag = 1'b1;
      end
      n.irq = q.rx_irq_en;
    end
    if (ovf) begin
      n.overrun_flag = 1'b1;
      n.irq = q.rx_irq_en;
    end
    if (pop) begin
      n.rp = !q.rp;
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

    // receive disabled or port off
    if (!n.rx_enable_bit) begin
      n.st = RX_IDLE;
      n.rx_idle_flag = 1'b1;
    end
    if (!n.port_on_bit) begin
      n.cnt = 2'h0;
      n.wp = 1'b0;
      n.rp = 1'b0;
      n.fifo = '0;
      n.rx_enable_bit = 1'b0;
      n.rx_avail_flag = 1'b0;
      n.overrun_flag = 1'b0;
      n.noise_flag = 1'b0;
      n.rx_idle_flag = 1'b1;
      n.st = RX_IDLE;
      n.irq = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;
      q.rx_idle_flag <= 1'b1;
      q.baud_divisor <= urx_pkg::DIV_RESET;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready_o = q.awrdy;
  assign s_axi_wready_o = q.wrdy;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arrdy;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign rx_irq_o = q.irq;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_avail_buffered: assert property (
    q.cnt != 2'h0 |-> q.rx_avail_flag)
    else $error("buffer holds data but avail low");

  a_overrun_keeps: assert property (
    ovf |=> q.overrun_flag && q.cnt == 2'h2 && q.fifo == $past(q.fifo))
    else $error("overrun disturbed buffer");

  a_irq_cause: assert property (
    rx_irq_o |-> $past(push || ovf) && $past(q.rx_irq_en))
    else $error("irq without transfer or overrun");

  a_idle_busy: assert property (
    q.st == RX_DATA || q.st == RX_STOP |-> !q.rx_idle_flag)
    else $error("idle high during frame");

  a_off_clear: assert property (
    !q.port_on_bit |-> q.cnt == 2'h0 && q.rx_idle_flag && !q.rx_enable_bit
      && !q.overrun_flag && !q.rx_avail_flag)
    else $error("port off did not clear");

  a_rxen_search: assert property (
    !q.rx_enable_bit |-> q.st == RX_IDLE)
    else $error("receiver active while disabled");

  a_phase_step: assert property (
    q.tick ##1 q.st == RX_DATA |-> q.ph == 4'($past(q.ph) + 4'h1))
    else $error("phase did not step on tick");

  a_payload_mask: assert property (
    push && q.parity_en && !q.word_length_sel
      |=> q.fifo[$past(q.wp)][8:7] == 2'h0)
    else $error("parity bit leaked into payload");

  a_flag_hold: assert property (
    q.overrun_flag && !pop && !(q.armed && q.rvalid == 1'b0 && q.arrdy
      && s_axi_arvalid_i && s_axi_araddr_i == urx_pkg::OFF_DATA)
      && n.port_on_bit |=> q.overrun_flag)
    else $error("overrun cleared without sequence");

endmodule : urx_receiver
`default_nettype wire

// ### urx_pkg.sv
`default_nettype none
package urx_pkg;
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam int ST_AVAIL = 0;
  localparam int ST_OVR = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_PAR = 4;
  localparam int ST_IDLE = 5;
  localparam int CT_ON = 0;
  localparam int CT_RXEN = 1;
  localparam int CT_WL = 2;
  localparam int CT_PEN = 3;
  localparam int CT_PTYPE = 4;
  localparam int CT_STOP2 = 5;
  localparam int CT_IRQEN = 6;
  localparam int CT_NINTH = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_PE = 10;
  localparam int ENT_W = 11;
  localparam logic [3:0] PH_SAMP_A = 4'h7;
  localparam logic [3:0] PH_SAMP_B = 4'h8;
  localparam logic [3:0] PH_SAMP_C = 4'h9;
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : urx_pkg
`default_nettype wire

// ### urx_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model #(
  parameter int BIT_CLKS = 64
) (
  input wire logic mclk_i, // system clock
  output logic line_o      // serial line, driven high when idle
);
  initial line_o = 1'b1;

  task automatic hold_bits(input logic v, input int nb);
    line_o <= v;
    repeat (nb * BIT_CLKS) @(posedge mclk_i);
  endtask : hold_bits

  // frame: start, nd data lsb first, ns stop bits from stp; gb picks a glitched bit
  task automatic send(input logic [8:0] w, input int nd, input logic [1:0] stp,
                      input int ns, input int gb);
    int i;
    hold_bits(1'b0, 1);
    for (i = 0; i < nd; i++) begin
      line_o <= w[i];
      repeat (32) @(posedge mclk_i);
      // four clocks always cover exactly one of the three votes
      if (i == gb) line_o <= ~w[i];
      repeat (4) @(posedge mclk_i);
      line_o <= w[i];
      repeat (BIT_CLKS - 36) @(posedge mclk_i);
    end
    for (i = 0; i < ns; i++) hold_bits(stp[i], 1);
    line_o <= 1'b1;
  endtask : send
endmodule : urx_tx_model
`default_nettype wire

// ### urx_receiver_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module urx_receiver_tb_top;
  typedef struct {
    logic [7:0] ctrl;
    logic [8:0] w;
    int nd;
    logic [1:0] stp;
    int ns;
    int gb;
    logic [7:0] data;
    logic [5:0] st;
    logic ninth;
    int irqs;
  } urx_row_t;
  logic mclk_i, rst_i, line, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int err_total, n_compared, irq_cnt, k;
  urx_row_t rows[11] = '{
    '{8'h43, 9'h0A5, 8, 2'b01, 1, 99, 8'hA5, 6'h21, 1'b0, 1},
    '{8'h47, 9'h15A, 9, 2'b01, 1, 99, 8'h5A, 6'h21, 1'b1, 1},
    '{8'h4B, 9'h035, 8, 2'b01, 1, 99, 8'h35, 6'h21, 1'b0, 1},
    '{8'h4B, 9'h0B5, 8, 2'b01, 1, 99, 8'h35, 6'h31, 1'b0, 1},
    '{8'h5B, 9'h0B5, 8, 2'b01, 1, 99, 8'h35, 6'h21, 1'b0, 1},
    '{8'h5B, 9'h035, 8, 2'b01, 1, 99, 8'h35, 6'h31, 1'b0, 1},
    '{8'h43, 9'h03C, 8, 2'b00, 1, 99, 8'h3C, 6'h29, 1'b0, 1},
    '{8'h63, 9'h0C3, 8, 2'b01, 2, 99, 8'hC3, 6'h29, 1'b0, 1},
    '{8'h63, 9'h0C3, 8, 2'b11, 2, 99, 8'hC3, 6'h21, 1'b0, 1},
    '{8'h43, 9'h00F, 8, 2'b01, 1, 2, 8'h0F, 6'h25, 1'b0, 1},
    '{8'h07, 9'h0E1, 9, 2'b01, 1, 99, 8'hE1, 6'h21, 1'b0, 0}
  };

  urx_receiver i_urx_receiver (
    .mclk_i(mclk_i), .rst_i(rst_i), .serial_in_pin_i(line),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_irq_o(irq)
  );
  urx_tx_model #(.BIT_CLKS(64)) i_urx_tx_model (.mclk_i(mclk_i), .line_o(line));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (irq === 1'b1) irq_cnt++;
  end
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    results();
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask : rchk

  task automatic results;
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  ////////////////////////////////////////
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rchk(urx_pkg::OFF_STAT, 32'h20);
    rchk(urx_pkg::OFF_CTRL, 32'h0);
    rchk(8'h10, 32'h0);
    chk({30'h0, rs}, {30'h0, urx_pkg::RESP_SLVERR});
    wr(8'h14, 32'h0);
    chk({30'h0, rs}, {30'h0, urx_pkg::RESP_SLVERR});
    wr(urx_pkg::OFF_CTRL, 32'h41);
    wr(urx_pkg::OFF_BAUD, 32'h3);
    rchk(urx_pkg::OFF_BAUD, 32'h3);
    i_urx_tx_model.send(9'h0A5, 8, 2'b01, 1, 99);
    repeat (8) @(posedge mclk_i);
    rchk(urx_pkg::OFF_STAT, 32'h20);
    foreach (rows[k]) begin
      wr(urx_pkg::OFF_CTRL, {24'h0, rows[k].ctrl});
      irq_cnt = 0;
      i_urx_tx_model.send(rows[k].w, rows[k].nd, rows[k].stp, rows[k].ns, rows[k].gb);
      repeat (8) @(posedge mclk_i);
      rchk(urx_pkg::OFF_CTRL, {23'h0, rows[k].ninth, rows[k].ctrl});
      rchk(urx_pkg::OFF_STAT, {26'h0, rows[k].st});
      rchk(urx_pkg::OFF_DATA, {24'h0, rows[k].data});
      rchk(urx_pkg::OFF_STAT, 32'h20);
      chk(32'(irq_cnt), 32'(rows[k].irqs));
    end
    wr(urx_pkg::OFF_CTRL, 32'h43);
    irq_cnt = 0;
    for (k = 1; k < 4; k++) begin
      i_urx_tx_model.send(9'(8'h11 * k), 8, 2'b01, 1, 99);
      @(posedge mclk_i);
    end
    repeat (8) @(posedge mclk_i);
    chk(32'(irq_cnt), 32'h3);
    rchk(urx_pkg::OFF_STAT, 32'h23);
    rchk(urx_pkg::OFF_DATA, 32'h11);
    rchk(urx_pkg::OFF_DATA, 32'h22);
    rchk(urx_pkg::OFF_STAT, 32'h21);
    rchk(urx_pkg::OFF_DATA, 32'h22);
    rchk(urx_pkg::OFF_STAT, 32'h20);
    irq_cnt = 0;
    fork
      i_urx_tx_model.hold_bits(1'b0, 14);
      begin
        repeat (192) @(posedge mclk_i);
        rchk(urx_pkg::OFF_STAT, 32'h0);
      end
    join
    i_urx_tx_model.hold_bits(1'b1, 2);
    i_urx_tx_model.send(9'h05A, 8, 2'b01, 1, 99);
    repeat (8) @(posedge mclk_i);
    chk(32'(irq_cnt), 32'h2);
    rchk(urx_pkg::OFF_STAT, 32'h29);
    rchk(urx_pkg::OFF_DATA, 32'h0);
    rchk(urx_pkg::OFF_STAT, 32'h21);
    rchk(urx_pkg::OFF_DATA, 32'h5A);
    i_urx_tx_model.send(9'h077, 8, 2'b01, 1, 99);
    repeat (8) @(posedge mclk_i);
    wr(urx_pkg::OFF_CTRL, 32'h46);
    rchk(urx_pkg::OFF_CTRL, 32'h44);
    rchk(urx_pkg::OFF_STAT, 32'h20);
    // error word buffered, then a reset in mid-run
    wr(urx_pkg::OFF_CTRL, 32'h5B);
    i_urx_tx_model.send(9'h035, 8, 2'b00, 1, 99);
    repeat (8) @(posedge mclk_i);
    rchk(urx_pkg::OFF_STAT, 32'h39);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rchk(urx_pkg::OFF_STAT, 32'h20);
    rchk(urx_pkg::OFF_CTRL, 32'h0);
    results();
  end
endmodule : urx_receiver_tb_top
`default_nettype wire
